// ### pbt_pkg.sv
// Constants shared by the proximity baseline tracker
package pbt_pkg;
  localparam int DATA_W = 14;
  localparam int CH_W = 2;
  localparam int WIN_W = 3;
  localparam int MULT_W = 4;
  localparam int MULT_FRAC_SHIFT = 2;
  localparam int ACC_W = DATA_W + 7;
  localparam int CNT_W = 8;
  localparam logic [7:0] CFG_ADDR = 8'hd9;
  localparam logic [7:0] CFG_RESET = 8'h0c;
  localparam logic [7:0] CFG_WMASK = 8'hcf;
  localparam int AUTO_THR_BIT = 7;
  localparam int AUTO_OFS_BIT = 6;
  localparam int AUTO_BASE_BIT = 3;
  localparam int WIN_LSB = 0;
  localparam logic [DATA_W-1:0] BASE_RESET = 14'h3fff;
  localparam logic [DATA_W-1:0] THR_RESET = 14'h0000;
endpackage

// ### pbt_avg_if.sv
// Carrier between the tracker and its window averager
`timescale 1ns/10ps
interface pbt_avg_if;
  import pbt_pkg::*;
  logic [WIN_W-1:0] window;
  logic sample_valid;
  logic [DATA_W-1:0] sample_data;
  logic avg_valid;
  logic [DATA_W-1:0] avg_value;
  modport tracker (output window, output sample_valid, output sample_data,
                   input avg_valid, input avg_value);
  modport avg (input window, input sample_valid, input sample_data,
               output avg_valid, output avg_value);
endinterface

// ### pbt_window_avg.sv
// Window averager producing the measured baseline
`timescale 1ns/10ps
module pbt_window_avg (
  input wire logic clk,
  input wire logic reset,
  pbt_avg_if.avg bus
);
  import pbt_pkg::*;
  logic [ACC_W-1:0] acc;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] last_count;
  logic [ACC_W-1:0] next_acc;
  logic window_end;

  assign last_count = CNT_W'((9'h001 << bus.window) - 9'h001);
  assign next_acc = acc + ACC_W'(bus.sample_data);
  assign window_end = bus.sample_valid && (count == last_count);

  // Accumulate samples over 2^window
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc <= '0;
      count <= '0;
    end else if (bus.sample_valid) begin
      if (window_end) begin
        acc <= '0;
        count <= '0;
      end else begin
        acc <= next_acc;
        count <= count + 8'h01;
      end
    end
  end

  // Average published at window end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus.avg_valid <= 1'b0;
      bus.avg_value <= '0;
    end else begin
      bus.avg_valid <= window_end;
      if (window_end) begin
        bus.avg_value <= DATA_W'(next_acc >> bus.window);
      end
    end
  end

  property p_avg_at_end;
    @(posedge clk) disable iff (reset)
    bus.sample_valid && count == last_count |=> bus.avg_valid && count == 8'h00;
  endproperty
  a_avg_at_end: assert property (p_avg_at_end) else $error("average missed window end");

  property p_no_early_avg;
    @(posedge clk) disable iff (reset)
    bus.sample_valid && count != last_count |=> !bus.avg_valid;
  endproperty
  a_no_early_avg: assert property (p_no_early_avg) else $error("average before window end");
endmodule

// ### pbt_tracker.sv
// Proximity baseline tracker with auto thresholds and offset trim
`timescale 1ns/10ps
module pbt_tracker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [pbt_pkg::MULT_W-1:0] threshold_multiplier,
  input wire logic prox_mode,
  input wire logic sample_valid,
  input wire logic [pbt_pkg::DATA_W-1:0] sample_data,
  input wire logic [pbt_pkg::CH_W-1:0] sample_channel,
  input wire logic clear_baseline_flag,
  input wire logic clear_offset_flag,
  output logic [pbt_pkg::DATA_W-1:0] stored_baseline,
  output logic [pbt_pkg::DATA_W-1:0] measured_baseline,
  output logic [pbt_pkg::DATA_W-1:0] gesture_entry_threshold,
  output logic [pbt_pkg::DATA_W-1:0] gesture_exit_threshold,
  output logic baseline_changed_flag,
  output logic offset_changed_flag,
  output logic offset_decrement,
  output logic [pbt_pkg::CH_W-1:0] offset_decrement_channel
);
  import pbt_pkg::*;
  logic [7:0] baseline_tracking_config;
  logic auto_threshold_enable;
  logic auto_offset_decrement_enable;
  logic auto_baseline_enable;
  logic baseline_update;
  logic zero_sample;
  logic [DATA_W+MULT_W-1:0] scaled;
  logic [DATA_W+MULT_W-1:0] next_threshold_wide;
  logic [DATA_W-1:0] next_threshold;
  pbt_avg_if avg_bus ();

  assign auto_threshold_enable = baseline_tracking_config[AUTO_THR_BIT];
  assign auto_offset_decrement_enable = baseline_tracking_config[AUTO_OFS_BIT];
  assign auto_baseline_enable = baseline_tracking_config[AUTO_BASE_BIT];
  assign avg_bus.window = baseline_tracking_config[WIN_LSB +: WIN_W];
  assign avg_bus.sample_valid = sample_valid && prox_mode;
  assign avg_bus.sample_data = sample_data;

  pbt_window_avg u_avg (
    .clk(clk),
    .reset(reset),
    .bus(avg_bus.avg)
  );

  assign baseline_update = avg_bus.avg_valid && auto_baseline_enable &&
                           (avg_bus.avg_value < stored_baseline);
  assign zero_sample = sample_valid && prox_mode && (sample_data == '0);

  // Factor is 1 + multiplier/4, saturated to the data width
  assign scaled = (DATA_W+MULT_W)'(avg_bus.avg_value) *
                  (DATA_W+MULT_W)'(threshold_multiplier);
  assign next_threshold_wide = (DATA_W+MULT_W)'(avg_bus.avg_value) +
                               (scaled >> MULT_FRAC_SHIFT);
  assign next_threshold = (|next_threshold_wide[DATA_W+MULT_W-1:DATA_W]) ? {DATA_W{1'b1}} :
                          next_threshold_wide[DATA_W-1:0];

  // Configuration register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      baseline_tracking_config <= CFG_RESET;
    end else if (reg_write && reg_addr == CFG_ADDR) begin
      baseline_tracking_config <= reg_wdata & CFG_WMASK;
    end
  end

  // Register read data
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_addr == CFG_ADDR) begin
      reg_rdata <= baseline_tracking_config;
    end else begin
      reg_rdata <= '0;
    end
  end

  // Measured baseline
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      measured_baseline <= '0;
    end else if (avg_bus.avg_valid) begin
      measured_baseline <= avg_bus.avg_value;
    end
  end

  // Stored baseline
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stored_baseline <= BASE_RESET;
    end else if (baseline_update) begin
      stored_baseline <= avg_bus.avg_value;
    end
  end

  // Gesture thresholds, same step as baseline
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gesture_entry_threshold <= THR_RESET;
      gesture_exit_threshold <= THR_RESET;
    end else if (baseline_update && auto_threshold_enable) begin
      gesture_entry_threshold <= next_threshold;
      gesture_exit_threshold <= next_threshold;
    end
  end

  // Sticky flags, set beats clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      baseline_changed_flag <= 1'b0;
      offset_changed_flag <= 1'b0;
    end else begin
      if (baseline_update) begin
        baseline_changed_flag <= 1'b1;
      end else if (clear_baseline_flag) begin
        baseline_changed_flag <= 1'b0;
      end
      if (zero_sample && auto_offset_decrement_enable) begin
        offset_changed_flag <= 1'b1;
      end else if (clear_offset_flag) begin
        offset_changed_flag <= 1'b0;
      end
    end
  end

  // Offset decrement request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      offset_decrement <= 1'b0;
      offset_decrement_channel <= '0;
    end else begin
      offset_decrement <= zero_sample && auto_offset_decrement_enable;
      if (zero_sample) begin
        offset_decrement_channel <= sample_channel;
      end
    end
  end

  sequence s_update;
    avg_bus.avg_valid && auto_baseline_enable && avg_bus.avg_value < stored_baseline;
  endsequence

  sequence s_zero_trim;
    sample_valid && prox_mode && sample_data == '0 && auto_offset_decrement_enable;
  endsequence

  property p_base_copy;
    @(posedge clk) disable iff (reset)
    s_update |=> stored_baseline == $past(avg_bus.avg_value);
  endproperty
  a_base_copy: assert property (p_base_copy) else $error("baseline not copied");

  property p_base_hold;
    @(posedge clk) disable iff (reset)
    !baseline_update |=> stored_baseline == $past(stored_baseline);
  endproperty
  a_base_hold: assert property (p_base_hold) else $error("baseline changed unexpectedly");

  property p_base_flag;
    @(posedge clk) disable iff (reset)
    s_update |=> baseline_changed_flag ##1 (baseline_changed_flag || $past(clear_baseline_flag));
  endproperty
  a_base_flag: assert property (p_base_flag) else $error("baseline flag not raised");

  property p_thr_write;
    @(posedge clk) disable iff (reset)
    s_update ##0 auto_threshold_enable |=>
      gesture_entry_threshold == $past(next_threshold) &&
      gesture_exit_threshold == gesture_entry_threshold;
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("thresholds not rewritten");

  property p_thr_unity;
    @(posedge clk) disable iff (reset)
    s_update ##0 auto_threshold_enable && threshold_multiplier == '0 |=>
      gesture_entry_threshold == stored_baseline;
  endproperty
  a_thr_unity: assert property (p_thr_unity) else $error("multiplier not applied");

  property p_thr_hold;
    @(posedge clk) disable iff (reset)
    !(baseline_update && auto_threshold_enable) |=> $stable(gesture_exit_threshold);
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold changed off update");

  property p_ofs_dec;
    @(posedge clk) disable iff (reset)
    s_zero_trim |=> offset_decrement && offset_changed_flag &&
      offset_decrement_channel == $past(sample_channel);
  endproperty
  a_ofs_dec: assert property (p_ofs_dec) else $error("offset not decremented");

  property p_ofs_flag_only;
    @(posedge clk) disable iff (reset)
    offset_decrement |-> offset_changed_flag;
  endproperty
  a_ofs_flag_only: assert property (p_ofs_flag_only) else $error("offset flag missing");

  property p_cfg_reset;
    @(posedge clk) disable iff (reset)
    $fell(reset) |-> baseline_tracking_config == CFG_RESET;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong");
endmodule

// ### pbt_prox_engine.sv
// Proximity measurement engine model feeding result pulses
`timescale 1ns/10ps
module pbt_prox_engine (
  input wire logic clk,
  output logic sample_valid,
  output logic [pbt_pkg::DATA_W-1:0] sample_data,
  output logic [pbt_pkg::CH_W-1:0] sample_channel
);
  import pbt_pkg::*;
  initial begin
    sample_valid = 1'b0;
    sample_data = '0;
    sample_channel = '0;
  end
  // One result per call, held over one rising edge
  task automatic send(input logic [DATA_W-1:0] d, input logic [CH_W-1:0] ch);
    @(negedge clk);
    sample_valid = 1'b1;
    sample_data = d;
    sample_channel = ch;
  endtask
  // Released lines stop showing the last result
  task automatic idle();
    @(negedge clk);
    sample_valid = 1'b0;
    sample_data = ~sample_data;
    sample_channel = ~sample_channel;
  endtask
endmodule

// ### prox_baseline_tracker_bench.sv
// Self-checking bench for the proximity baseline tracker
`timescale 1ns/10ps
module prox_baseline_tracker_bench;
  import pbt_pkg::*;
  logic clk, reset, reg_write, pm, clr_b, clr_o, sv, bf, of, dec;
  logic [7:0] ra, rw, rr, m_cfg;
  logic [MULT_W-1:0] mult;
  logic [DATA_W-1:0] sd, st, ms, en, ex, m_st, m_ms, m_thr;
  logic [CH_W-1:0] sc, och, lc;
  logic m_bf, m_of, xd;
  int n_errors = 0, checks = 0, seed = 8609, sum, t, d;
  int q[$];
  pbt_tracker i_dut (.clk(clk), .reset(reset), .reg_addr(ra), .reg_write(reg_write),
    .reg_wdata(rw), .reg_rdata(rr), .threshold_multiplier(mult), .prox_mode(pm),
    .sample_valid(sv), .sample_data(sd), .sample_channel(sc), .clear_baseline_flag(clr_b),
    .clear_offset_flag(clr_o), .stored_baseline(st), .measured_baseline(ms),
    .gesture_entry_threshold(en), .gesture_exit_threshold(ex), .baseline_changed_flag(bf),
    .offset_changed_flag(of), .offset_decrement(dec), .offset_decrement_channel(och));
  pbt_prox_engine i_eng (.clk(clk), .sample_valid(sv), .sample_data(sd), .sample_channel(sc));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cmp(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    ra = a;
    rw = v;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    if (a == CFG_ADDR) m_cfg = v & CFG_WMASK;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    ra = a;
    @(negedge clk);
    cmp({6'h00, rr}, {6'h00, e});
  endtask
  task automatic chk();
    cmp(ms, m_ms);
    cmp(st, m_st);
    cmp(en, m_thr);
    cmp(ex, m_thr);
    cmp({13'h0000, bf}, {13'h0000, m_bf});
    cmp({13'h0000, of}, {13'h0000, m_of});
  endtask
  // One full window of results, random gaps, then the model update
  task automatic win(input int nw, input int lim, input logic p);
    q.delete();
    pm = p;
    for (int i = 0; i < (1 << nw); i++) begin
      d = lim ? $unsigned($random(seed)) % lim : 0;
      lc = CH_W'($random(seed));
      q.push_back(d);
      if ($random(seed) & 1) i_eng.idle();
      i_eng.send(DATA_W'(d), lc);
    end
    i_eng.idle();
    xd = p && lim == 0 && m_cfg[AUTO_OFS_BIT];
    cmp({13'h0000, dec}, {13'h0000, xd});
    if (xd) cmp({12'h000, och}, {12'h000, lc});
    if (xd) m_of = 1'b1;
    sum = 0;
    foreach (q[k]) sum += q[k];
    if (p) begin
      m_ms = DATA_W'(sum >> nw);
      if (m_cfg[AUTO_BASE_BIT] && m_ms < m_st) begin
        m_st = m_ms;
        m_bf = 1'b1;
        t = m_st + ((m_st * mult) >> MULT_FRAC_SHIFT);
        if (m_cfg[AUTO_THR_BIT]) m_thr = (t > 16383) ? 14'h3fff : DATA_W'(t);
      end
    end
    @(negedge clk);
    @(negedge clk);
    chk();
  endtask
  initial begin
    #200000;
    n_errors++;
    results();
  end
  initial begin
    reset = 1'b1;
    ra = CFG_ADDR;
    rw = 8'h00;
    reg_write = 1'b0;
    pm = 1'b1;
    mult = 4'h0;
    clr_b = 1'b0;
    clr_o = 1'b0;
    m_cfg = CFG_RESET;
    m_st = BASE_RESET;
    m_ms = '0;
    m_thr = '0;
    m_bf = 1'b0;
    m_of = 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    rd(CFG_ADDR, 8'h0c);
    chk();
    win(4, 16000, 1'b1);
    wr(CFG_ADDR, 8'hff);
    rd(CFG_ADDR, 8'hcf);
    rd(8'h00, 8'h00);
    for (int w = 0; w < 8; w++) begin
      mult = MULT_W'($random(seed));
      wr(CFG_ADDR, 8'h88 | w[7:0]);
      win(w, 12000 - w * 1400, 1'b1);
    end
    wr(CFG_ADDR, 8'h82);
    win(2, 40, 1'b1);
    wr(CFG_ADDR, 8'hc8);
    win(0, 0, 1'b0);
    win(0, 0, 1'b1);
    wr(CFG_ADDR, 8'h08);
    win(0, 0, 1'b1);
    @(negedge clk);
    clr_b = 1'b1;
    clr_o = 1'b1;
    @(negedge clk);
    clr_b = 1'b0;
    clr_o = 1'b0;
    @(negedge clk);
    m_bf = 1'b0;
    m_of = 1'b0;
    chk();
    results();
  end
endmodule
